//--- hdl/urps_pkg.sv
// shared constants for the root port status block
package urps_pkg;

    localparam int          URPS_ADDR_W      = 4;
    localparam int          URPS_DATA_W      = 16;

    // register map
    localparam logic [3:0]  URPS_PORTSC_OFS  = 4'h0;

    // field positions inside the port status/control register
    localparam int          URPS_CONN_BIT    = 0;
    localparam int          URPS_CSC_BIT     = 1;
    localparam int          URPS_PE_BIT      = 2;
    localparam int          URPS_PEC_BIT     = 3;

    // values after reset
    localparam logic        URPS_CONN_RST    = 1'h0;
    localparam logic        URPS_CSC_RST     = 1'h0;
    localparam logic        URPS_PE_RST      = 1'h0;
    localparam logic        URPS_PEC_RST     = 1'h0;
    localparam logic [15:0] URPS_RDATA_RST   = 16'h0000;
    localparam logic [1:0]  URPS_REPORT_RST  = 2'h0;

    // port enable state machine
    typedef enum logic [1:0] {
        URPS_DISABLED,
        URPS_ENABLING,
        URPS_ENABLED,
        URPS_DISABLING
    } urps_state_t;

endpackage : urps_pkg

//--- hdl/urps_conn_detect.sv
// connect status register and change detector for the attached device
module urps_conn_detect
    import urps_pkg::*;
(
    input  wire logic clk_sys,     // system clock
    input  wire logic rst_n,       // async reset, active low
    input  wire logic devPresent,  // device attached on the port
    output logic      connNow,     // registered connect status
    output logic      connChange   // one-cycle pulse on any change
);

    logic connReg;
    logic connNext;
    logic changeReg;
    logic changeNext;

    always_comb begin
        connNext   = devPresent;
        changeNext = devPresent != connReg;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            connReg   <= URPS_CONN_RST;
            changeReg <= 1'b0;
        end else begin
            connReg   <= connNext;
            changeReg <= changeNext;
        end
    end

    assign connNow    = connReg;
    assign connChange = changeReg;

endmodule : urps_conn_detect

//--- hdl/urps_port.sv
// one root port: connect status, enable control and their change flags
//
// Operation
// - The enable-change flag is set only when the port is disabled by a disconnect or by a fault seen at the end-of-frame check point.
// - Both change flags clear only when software writes a one to their bit, and a zero leaves them alone.
// - The port becomes enabled only through a software write of one, never by hardware itself.
// - A disconnect or other fault disables the port, and a software write of zero disables it too.
// - The readable enable bit changes only once the port has changed, waiting for any bus transaction in flight.
// - Every change of connect status sets the connect-change flag, and further changes while set merge into it.
// - A pending change is reported only once to a request on the status change endpoint.
// - The connect status bit shows live whether a device is attached, regardless of what set the change flag.
//
// The register offsets and strobed register access were left to the implementer.
module urps_port
    import urps_pkg::*;
#(
    parameter int ADDR_W = URPS_ADDR_W,
    parameter int DATA_W = URPS_DATA_W
)(
    input  wire logic              clk_sys,      // system clock, 250 MHz
    input  wire logic              rst_n,        // async reset, active low
    input  wire logic [ADDR_W-1:0] regAddr,      // register address
    input  wire logic [DATA_W-1:0] regWdata,     // register write data
    input  wire logic              regWrite,     // write strobe
    input  wire logic              regRead,      // read strobe
    output logic      [DATA_W-1:0] regRdata,     // read data, cycle after strobe
    input  wire logic              devPresent,   // device attached on the port
    input  wire logic              faultEvent,   // other port fault, pulse
    input  wire logic              eof2Strobe,   // end-of-frame check point, pulse
    input  wire logic              eof2Fault,    // fault condition seen at that point
    input  wire logic              xferBusy,     // transaction in progress on the port
    input  wire logic              statusReq,    // request to status change endpoint
    output logic                   portEnabled,  // port enable state
    output logic                   reportValid,  // answer to statusReq, pulse
    output logic                   reportChange, // a change is being reported
    output logic      [1:0]        reportFlags   // {enable change, connect change}
);

    // write-one-to-clear flag; a same-cycle hardware set wins over the clear
    function automatic logic urps_w1c_next(
        input logic cur, // present flag value
        input logic clr, // software wrote a one to the bit
        input logic set  // hardware event in this cycle
    );
        logic nxt;
        nxt = cur;
        if (clr) begin
            nxt = 1'b0;
        end
        if (set) begin
            nxt = 1'b1;
        end
        return nxt;
    endfunction : urps_w1c_next

    // status word of the port register; reserved bits read zero
    function automatic logic [DATA_W-1:0] urps_status_word(
        input logic conn, // connect status
        input logic csc,  // connect change flag
        input logic pe,   // port enabled
        input logic pec   // enable change flag
    );
        logic [DATA_W-1:0] word;
        word                = DATA_W'(URPS_RDATA_RST);
        word[URPS_CONN_BIT] = conn;
        word[URPS_CSC_BIT]  = csc;
        word[URPS_PE_BIT]   = pe;
        word[URPS_PEC_BIT]  = pec;
        return word;
    endfunction : urps_status_word

    // connect tracking
    logic connNow;
    logic connChange;

    urps_conn_detect u_conn (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .devPresent (devPresent),
        .connNow    (connNow),
        .connChange (connChange)
    );

    // register access decode
    logic portHit;
    logic wrPort;
    logic swEnReq;
    logic swDisReq;
    logic cscClr;
    logic pecClr;

    always_comb begin
        portHit  = regAddr == ADDR_W'(URPS_PORTSC_OFS);
        wrPort   = regWrite && portHit;
        swEnReq  = wrPort && regWdata[URPS_PE_BIT];
        swDisReq = wrPort && !regWdata[URPS_PE_BIT];
        cscClr   = wrPort && regWdata[URPS_CSC_BIT];
        pecClr   = wrPort && regWdata[URPS_PEC_BIT];
    end

    // fault sources that take the port down
    logic disconnect;
    logic eofFault;
    logic pecCause;
    logic faultHit;

    always_comb begin
        disconnect = connChange && !connNow;
        eofFault   = eof2Strobe && eof2Fault;
        // other faults disable too, but only these two may flag the change
        pecCause   = disconnect || eofFault;
        faultHit   = pecCause || faultEvent;
    end

    // enable state machine
    urps_state_t stateReg;
    urps_state_t stateNext;
    logic        faultCauseReg;
    logic        faultCauseNext;
    logic        portEnReg;
    logic        portEnNext;
    logic        pecSet;

    always_comb begin
        stateNext      = stateReg;
        faultCauseNext = faultCauseReg;
        pecSet         = 1'b0;
        case (stateReg)
            URPS_DISABLED: begin
                faultCauseNext = 1'b0;
                // no device, nothing to enable
                if (swEnReq && connNow && !disconnect) begin
                    stateNext = URPS_ENABLING;
                end
            end
            URPS_ENABLING: begin
                if (faultHit || swDisReq) begin
                    // never seen enabled, so no enable change to flag
                    stateNext = URPS_DISABLED;
                end else if (!xferBusy) begin
                    stateNext = URPS_ENABLED;
                end
            end
            URPS_ENABLED: begin
                if (faultHit) begin
                    stateNext      = URPS_DISABLING;
                    faultCauseNext = pecCause;
                end else if (swDisReq) begin
                    stateNext      = URPS_DISABLING;
                    faultCauseNext = 1'b0;
                end
            end
            URPS_DISABLING: begin
                // a disconnect while draining still counts as the cause
                if (pecCause) begin
                    faultCauseNext = 1'b1;
                end
                if (!xferBusy) begin
                    stateNext = URPS_DISABLED;
                    pecSet    = faultCauseReg || pecCause;
                end
            end
            default: begin
                stateNext      = URPS_DISABLED;
                faultCauseNext = 1'b0;
            end
        endcase
        // visible bit follows the real port, not the request
        portEnNext = stateNext == URPS_ENABLED || stateNext == URPS_DISABLING;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stateReg      <= URPS_DISABLED;
            faultCauseReg <= 1'b0;
            portEnReg     <= URPS_PE_RST;
        end else begin
            stateReg      <= stateNext;
            faultCauseReg <= faultCauseNext;
            portEnReg     <= portEnNext;
        end
    end

    // change flags, set wins over a same-cycle clear
    logic cscReg;
    logic cscNext;
    logic pecReg;
    logic pecNext;

    always_comb begin
        cscNext = urps_w1c_next(cscReg, cscClr, connChange);
        pecNext = urps_w1c_next(pecReg, pecClr, pecSet);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cscReg <= URPS_CSC_RST;
            pecReg <= URPS_PEC_RST;
        end else begin
            cscReg <= cscNext;
            pecReg <= pecNext;
        end
    end

    // status change endpoint: each new change reported once
    logic       reportPendReg;
    logic       reportPendNext;
    logic       reportValidReg;
    logic       reportValidNext;
    logic       reportChangeReg;
    logic       reportChangeNext;
    logic [1:0] reportFlagsReg;
    logic [1:0] reportFlagsNext;

    always_comb begin
        reportPendNext   = reportPendReg;
        reportValidNext  = statusReq;
        reportChangeNext = 1'b0;
        reportFlagsNext  = reportFlagsReg;
        if (statusReq) begin
            reportChangeNext = reportPendReg;
            reportFlagsNext  = {pecReg, cscReg};
            reportPendNext   = 1'b0;
        end
        // history between requests is merged; software sorts it out
        if (connChange || pecSet) begin
            reportPendNext = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reportPendReg   <= 1'b0;
            reportValidReg  <= 1'b0;
            reportChangeReg <= 1'b0;
            reportFlagsReg  <= URPS_REPORT_RST;
        end else begin
            reportPendReg   <= reportPendNext;
            reportValidReg  <= reportValidNext;
            reportChangeReg <= reportChangeNext;
            reportFlagsReg  <= reportFlagsNext;
        end
    end

    // read data, registered; unmapped addresses read zero
    logic [DATA_W-1:0] rdataReg;
    logic [DATA_W-1:0] rdataNext;

    always_comb begin
        rdataNext = DATA_W'(URPS_RDATA_RST);
        if (regRead && portHit) begin
            // connect bit is live, enable bit is the settled state
            rdataNext = urps_status_word(connNow, cscReg, portEnReg, pecReg);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdataReg <= DATA_W'(URPS_RDATA_RST);
        end else begin
            rdataReg <= rdataNext;
        end
    end

    assign regRdata     = rdataReg;
    assign portEnabled  = portEnReg;
    assign reportValid  = reportValidReg;
    assign reportChange = reportChangeReg;
    assign reportFlags  = reportFlagsReg;

endmodule : urps_port

//--- test/urps_port_assertions.sv
// checker for the root port status block, bound to its top module
module urps_port_chk
    import urps_pkg::*;
#(
    parameter int ADDR_W = URPS_ADDR_W,
    parameter int DATA_W = URPS_DATA_W
)(
    input wire logic              clk_sys,      // clock
    input wire logic              rst_n,        // reset
    input wire logic [ADDR_W-1:0] regAddr,      // address
    input wire logic [DATA_W-1:0] regWdata,     // wdata
    input wire logic              regWrite,     // wr
    input wire logic              regRead,      // rd
    input wire logic [DATA_W-1:0] regRdata,     // rdata
    input wire logic              devPresent,   // attached
    input wire logic              faultEvent,   // fault
    input wire logic              eof2Strobe,   // eof2
    input wire logic              eof2Fault,    // eof2 fault
    input wire logic              xferBusy,     // busy
    input wire logic              statusReq,    // request
    input wire logic              portEnabled,  // enabled
    input wire logic              reportValid,  // report
    input wire logic              reportChange, // change
    input wire logic [1:0]        reportFlags   // flags
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic swEnReg;
    logic swEnNext;
    logic pePrevReg;
    // last software enable request, dropped once the port falls
    always_comb begin
        swEnNext = swEnReg;
        if (pePrevReg && !portEnabled) swEnNext = 1'b0;
        if (regWrite && regAddr == URPS_PORTSC_OFS) swEnNext = regWdata[URPS_PE_BIT];
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            swEnReg   <= 1'b0;
            pePrevReg <= 1'b0;
        end else begin
            swEnReg   <= swEnNext;
            pePrevReg <= portEnabled;
        end
    end
    sequence enWr;
        regWrite && regAddr == URPS_PORTSC_OFS && regWdata[URPS_PE_BIT]
            && !portEnabled && $past(devPresent);
    endsequence
    sequence calm;
        !xferBusy && !faultEvent && !eof2Strobe && devPresent;
    endsequence
    sequence fltHit;
        portEnabled && faultEvent && !xferBusy;
    endsequence
    enable_time_a: assert property (enWr ##0 calm ##1 calm ##0 !regWrite |=> portEnabled)
        else $error("enable did not land in two cycles");
    sw_only_a: assert property ($rose(portEnabled) |-> swEnReg)
        else $error("port enabled without software request");
    busy_stable_a: assert property (xferBusy |=> $stable(portEnabled))
        else $error("enable state moved during a transaction");
    fault_disable_a: assert property (fltHit ##1 !xferBusy |=> !portEnabled)
        else $error("fault did not disable the port");
    conn_live_a: assert property ($past(regRead) && $past(regAddr) == URPS_PORTSC_OFS
        |-> regRdata[URPS_CONN_BIT] == $past(devPresent, 2))
        else $error("connect bit not live");
    report_pulse_a: assert property (statusReq ##1 !statusReq |-> reportValid ##1 !reportValid)
        else $error("report pulse wrong");
    rdata_idle_a: assert property (!$past(regRead) |-> regRdata == '0)
        else $error("read data outside read cycle");
    unmapped_rd_a: assert property ($past(regRead) && $past(regAddr) != URPS_PORTSC_OFS
        |-> regRdata == '0)
        else $error("unmapped read not zero");
    rsvd_zero_a: assert property (regRdata[DATA_W-1:4] == '0)
        else $error("reserved bits not zero");
endmodule : urps_port_chk

bind urps_port urps_port_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .devPresent(devPresent), .faultEvent(faultEvent), .eof2Strobe(eof2Strobe),
    .eof2Fault(eof2Fault), .xferBusy(xferBusy), .statusReq(statusReq),
    .portEnabled(portEnabled), .reportValid(reportValid),
    .reportChange(reportChange), .reportFlags(reportFlags));

//--- test/urps_dev_model.sv
// model of the device attached to the root port
module urps_dev_model (
    input  wire logic clk_sys,    // clock
    input  wire logic rst_n,      // reset
    input  wire logic attach,     // plug command
    input  wire logic busyCmd,    // start traffic
    output logic      devPresent, // attached
    output logic      xferBusy    // traffic on port
);
    timeunit 1ns;
    timeprecision 1ps;
    logic presNext;
    logic busyNext;
    // no traffic can run without a device
    always_comb begin
        presNext = attach;
        busyNext = busyCmd && devPresent;
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            devPresent <= 1'b0;
            xferBusy   <= 1'b0;
        end else begin
            devPresent <= presNext;
            xferBusy   <= busyNext;
        end
    end
endmodule : urps_dev_model

//--- test/tb.sv
// testbench for the root port status block
module tb
    import urps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                   clk_sys, rst_n, regWrite, regRead, faultEvent;
    logic                   eof2Strobe, eof2Fault, statusReq, attach, busyCmd;
    logic                   devPresent, xferBusy, portEnabled, reportValid, reportChange;
    logic [1:0]             reportFlags;
    logic [URPS_ADDR_W-1:0] regAddr;
    logic [URPS_DATA_W-1:0] regWdata, regRdata;
    int                     fails, totalChecks;

    urps_port uut (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .devPresent(devPresent), .faultEvent(faultEvent),
        .eof2Strobe(eof2Strobe), .eof2Fault(eof2Fault), .xferBusy(xferBusy),
        .statusReq(statusReq), .portEnabled(portEnabled), .reportValid(reportValid),
        .reportChange(reportChange), .reportFlags(reportFlags));
    urps_dev_model dev (.clk_sys(clk_sys), .rst_n(rst_n), .attach(attach),
        .busyCmd(busyCmd), .devPresent(devPresent), .xferBusy(xferBusy));

    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        totalChecks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t word %h want %h", $time, got, exp);
        end
    endtask : cmp16
    task automatic cmp1(input logic got, input logic exp);
        totalChecks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t bit %b want %b", $time, got, exp);
        end
    endtask : cmp1
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        #1 cmp16(regRdata, e);
    endtask : rd
    task automatic rep(input logic ch, input logic [1:0] fl);
        @(posedge clk_sys);
        statusReq <= 1'b1;
        @(posedge clk_sys);
        statusReq <= 1'b0;
        #1 cmp1(reportValid, 1'b1);
        cmp1(reportChange, ch);
        cmp16({14'h0, reportFlags}, {14'h0, fl});
    endtask : rep
    task automatic t_connect;
        attach <= 1'b1;
        tick(4);
        rd(4'h0, 16'h0003);
        wr(4'h0, 16'h0000);
        rd(4'h0, 16'h0003);
        wr(4'h0, 16'h0002);
        rd(4'h0, 16'h0001);
        attach <= 1'b0;
        tick(3);
        attach <= 1'b1;
        tick(4);
        rd(4'h0, 16'h0003);
        wr(4'h0, 16'h0002);
    endtask : t_connect
    task automatic t_enable;
        busyCmd <= 1'b1;
        wr(4'h0, 16'h0004);
        tick(4);
        cmp1(portEnabled, 1'b0);
        busyCmd <= 1'b0;
        tick(4);
        cmp1(portEnabled, 1'b1);
        rd(4'h0, 16'h0005);
    endtask : t_enable
    task automatic t_fault;
        @(posedge clk_sys);
        faultEvent <= 1'b1;
        @(posedge clk_sys);
        faultEvent <= 1'b0;
        tick(2);
        cmp1(portEnabled, 1'b0);
        rd(4'h0, 16'h0001);
        wr(4'h0, 16'h0008);
        rd(4'h0, 16'h0001);
    endtask : t_fault
    task automatic t_eof2(input logic flt, input logic [15:0] e);
        wr(4'h0, 16'h0004);
        tick(2);
        @(posedge clk_sys);
        eof2Fault  <= flt;
        eof2Strobe <= 1'b1;
        @(posedge clk_sys);
        eof2Strobe <= 1'b0;
        tick(3);
        rd(4'h0, e);
        wr(4'h0, 16'h0008);
        rd(4'h0, 16'h0001);
    endtask : t_eof2
    task automatic t_swdis;
        wr(4'h0, 16'h0004);
        tick(2);
        busyCmd <= 1'b1;
        wr(4'h0, 16'h0000);
        tick(2);
        cmp1(portEnabled, 1'b1);
        busyCmd <= 1'b0;
        tick(3);
        cmp1(portEnabled, 1'b0);
        rd(4'h0, 16'h0001);
    endtask : t_swdis
    task automatic t_report;
        rep(1'b1, 2'b00);
        rep(1'b0, 2'b00);
    endtask : t_report
    task automatic t_disc;
        wr(4'h0, 16'h0004);
        tick(3);
        attach <= 1'b0;
        tick(6);
        rd(4'h0, 16'h000a);
        rep(1'b1, 2'b11);
        wr(4'h0, 16'h000e);
        tick(3);
        cmp1(portEnabled, 1'b0);
        rd(4'h0, 16'h0000);
    endtask : t_disc
    task automatic final_report;
        if (fails == 0 && totalChecks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // far beyond the roughly 120 cycles the tests need
    initial begin
        #20000;
        fails++;
        final_report();
    end
    initial begin
        {rst_n, regWrite, regRead, faultEvent, eof2Strobe} = '0;
        {eof2Fault, statusReq, attach, busyCmd, fails, totalChecks} = '0;
        regAddr  = '0;
        regWdata = '0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(4'h0, 16'h0000);
        rd(4'h5, 16'h0000);
        t_connect();
        t_enable();
        t_fault();
        t_eof2(1'b0, 16'h0005);
        t_eof2(1'b1, 16'h0009);
        t_swdis();
        t_report();
        t_disc();
        final_report();
    end
endmodule : tb
